// >>> hw/ipl_bank.sv
`timescale 1ns/1ps
// How it works
// R1: nine 16-bit read/write priority registers on the register bus.
// R2: levels 0 to 15 for all sources; nmi never touched by them.
// R3: each register holds four 4-bit fields at 15:12, 11:8, 7:4, 3:0.
// R4: field is an unsigned level, 0000 lowest, 1111 highest.
// R5: reset clears every field to zero.
// R6: software writes zero into fields with no source behind them.
// R7: a source at level zero is masked and never accepted.
// R8: nmi has fixed level 16 and is always accepted.
// R9: reads return the last value written, or zero since reset.
module ipl_bank #(
    parameter int NUM_REGS = ipl_pkg::NUM_REGS
) (
    input wire logic clk,
    input wire logic reset,
    input wire ipl_pkg::ipl_apb_req_t apb_req,
    output ipl_pkg::ipl_apb_rsp_t apb_rsp,
    output logic [NUM_REGS*ipl_pkg::REG_W-1:0] src_level,
    input wire logic [NUM_REGS*ipl_pkg::FIELDS_PER_REG-1:0] src_req,
    input wire logic nmi_req,
    output logic [NUM_REGS*ipl_pkg::FIELDS_PER_REG-1:0] src_accept,
    output logic nmi_accept,
    output logic [4:0] nmi_level
);
    import ipl_pkg::*;

    localparam int NSRC = NUM_REGS * FIELDS_PER_REG;

    if (NUM_REGS < 1 || NUM_REGS > ipl_pkg::NUM_REGS) begin : g_bad_count
        $error("NUM_REGS must lie between 1 and the size of the offset map");
    end

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // misaligned or unlisted addresses miss; idx is only meaningful on a hit
    function automatic logic decode_hit(input logic [ADDR_W-1:0] addr);
        logic hit;
        hit = 1'b0;
        for (int r = 0; r < NUM_REGS; r++) begin
            if (addr == OFS_MAP[r*ADDR_W +: ADDR_W]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    function automatic logic [3:0] decode_idx(input logic [ADDR_W-1:0] addr);
        logic [3:0] idx;
        idx = 4'h0;
        for (int r = 0; r < NUM_REGS; r++) begin
            if (addr == OFS_MAP[r*ADDR_W +: ADDR_W]) begin
                idx = 4'(r);
            end
        end
        return idx;
    endfunction

    // byte lanes 0 and 1 carry the 16-bit register; upper lanes are ignored
    function automatic logic [REG_W-1:0] merge_lanes(input logic [REG_W-1:0] old_val,
                                                     input logic [DATA_W-1:0] wdata,
                                                     input logic [3:0] strb);
        logic [REG_W-1:0] merged;
        merged = old_val;
        if (strb[0]) begin
            merged[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            merged[15:8] = wdata[15:8];
        end
        return merged;
    endfunction

    // ----------------------------------------
    // bus phases
    // ----------------------------------------
    logic setup_phase;
    logic access_done;
    logic addr_hit;
    logic [3:0] addr_idx;

    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign access_done = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign addr_hit = decode_hit(apb_req.paddr);
    assign addr_idx = decode_idx(apb_req.paddr);

    // ----------------------------------------
    // priority registers
    // ----------------------------------------
    logic [REG_W-1:0] prio_reg [NUM_REGS];
    logic [REG_W-1:0] prio_next [NUM_REGS];

    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            prio_next[r] = prio_reg[r];
        end
        // strobed byte lanes stored as written: four independent fields, no field filtering [R1] [R3]
        if (access_done && apb_req.pwrite && addr_hit) begin
            prio_next[addr_idx] = merge_lanes(prio_reg[addr_idx], apb_req.pwdata, apb_req.pstrb);
        end
    end

    always_ff @(posedge clk) begin
        for (int r = 0; r < NUM_REGS; r++) begin
            if (reset) begin
                prio_reg[r] <= PRIO_RESET; // [R5]
            end else begin
                prio_reg[r] <= prio_next[r];
            end
        end
    end

    // levels leave straight from the register flops
    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            src_level[r*REG_W +: REG_W] = prio_reg[r]; // [R3] [R4]
        end
    end

    // ----------------------------------------
    // bus response
    // ----------------------------------------
    // one wait-free access cycle: answer is prepared in setup, shown in access
    ipl_apb_rsp_t rsp_next;

    always_comb begin
        rsp_next = '0;
        if (setup_phase) begin
            rsp_next.pready = 1'b1;
            if (!addr_hit) begin
                rsp_next.pslverr = 1'b1;
            end else if (!apb_req.pwrite) begin
                rsp_next.prdata = {16'h0000, prio_reg[addr_idx]}; // [R9]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp <= rsp_next;
        end
    end

    // ----------------------------------------
    // acceptance gate
    // ----------------------------------------
    // software is trusted to leave unused fields at zero, so their gate stays shut [R6]
    ipl_gate #(
        .NUM_SRC(NSRC)
    ) u_gate (
        .clk(clk),
        .reset(reset),
        .level(src_level),
        .src_req(src_req),
        .nmi_req(nmi_req),
        .accept_reg(src_accept),
        .nmi_accept_reg(nmi_accept),
        .nmi_level_reg(nmi_level)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [3:0] seen_idx;

    always_ff @(posedge clk) begin
        seen_idx <= addr_idx;
    end

    default clocking cb @(posedge clk); endclocking

    // own disable: the default one below would silence this check during reset
    reset_clears_bank_a: assert property (@(posedge clk) disable iff (1'b0) reset |=> src_level == '0) // [R5]
        else $error("bank not cleared by reset");

    default disable iff (reset);

    setup_gets_ready_a: assert property (setup_phase |=> apb_rsp.pready ##1 !apb_rsp.pready) // [R1]
        else $error("ready not a single access-cycle pulse");

    write_lands_a: assert property ( // [R3]
        access_done && apb_req.pwrite && addr_hit && apb_req.pstrb[1:0] == 2'b11
        |=> prio_reg[$past(addr_idx)] == $past(apb_req.pwdata[15:0]))
        else $error("written value not stored");

    read_returns_value_a: assert property ( // [R9]
        setup_phase && !apb_req.pwrite && addr_hit
        |=> apb_rsp.prdata == {16'h0000, prio_reg[$past(addr_idx)]} && !apb_rsp.pslverr)
        else $error("read data differs from stored value");

    read_keeps_bank_a: assert property ( // [R9]
        access_done && !apb_req.pwrite |=> prio_reg[seen_idx] == $past(prio_reg[seen_idx]))
        else $error("read altered a register");

    unmapped_error_a: assert property ( // [R1]
        setup_phase && !addr_hit |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
        else $error("unmapped access not flagged");

    nmi_ignores_bank_a: assert property ( // [R2]
        nmi_req && src_level == '0 |=> nmi_accept)
        else $error("nmi acceptance depends on bank contents");

endmodule

// >>> hw/ipl_gate.sv
`timescale 1ns/1ps
module ipl_gate #(
    parameter int NUM_SRC = ipl_pkg::NUM_SRC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [NUM_SRC*ipl_pkg::FIELD_W-1:0] level,
    input wire logic [NUM_SRC-1:0] src_req,
    input wire logic nmi_req,
    output logic [NUM_SRC-1:0] accept_reg,
    output logic nmi_accept_reg,
    output logic [4:0] nmi_level_reg
);
    import ipl_pkg::*;

    logic [NUM_SRC-1:0] accept_next;
    logic nmi_accept_next;
    logic [4:0] nmi_level_next;

    // ----------------------------------------
    // acceptance
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            // level zero masks the source regardless of request [R7] [R4]
            accept_next[i] = src_req[i] && (level[i*FIELD_W +: FIELD_W] != LEVEL_MASKED);
        end
        // nmi bypasses the bank entirely [R8] [R2]
        nmi_accept_next = nmi_req;
        nmi_level_next = NMI_LEVEL;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            accept_reg <= '0;
            nmi_accept_reg <= 1'b0;
            nmi_level_reg <= NMI_LEVEL;
        end else begin
            accept_reg <= accept_next;
            nmi_accept_reg <= nmi_accept_next;
            nmi_level_reg <= nmi_level_next;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    for (genvar g = 0; g < NUM_SRC; g++) begin : g_chk
        level_zero_mask_a: assert property ( // [R7]
            level[g*FIELD_W +: FIELD_W] == 4'h0 |=> !accept_reg[g])
            else $error("source accepted at level zero");
        level_accept_a: assert property ( // [R4]
            src_req[g] && level[g*FIELD_W +: FIELD_W] != 4'h0 |=> accept_reg[g])
            else $error("requesting source with nonzero level not accepted");
    end

    nmi_always_a: assert property ( // [R8]
        nmi_req |=> nmi_accept_reg && nmi_level_reg == 5'h10)
        else $error("nmi not accepted at level sixteen");

endmodule

// >>> hw/ipl_pkg.sv
package ipl_pkg;

    // ----------------------------------------
    // bank geometry
    // ----------------------------------------
    localparam int NUM_REGS = 9;
    localparam int FIELDS_PER_REG = 4;
    localparam int FIELD_W = 4;
    localparam int REG_W = 16;
    localparam int NUM_SRC = NUM_REGS * FIELDS_PER_REG;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_SHIFT = 2;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] OFS_PIN_IRQ_PRIORITY = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PRIO_BANK_D = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PRIO_BANK_E = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PRIO_BANK_F = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PRIO_BANK_G = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PRIO_BANK_H = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PRIO_BANK_I = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_PRIO_BANK_J = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_PRIO_BANK_K = 8'h20;
    localparam logic [NUM_REGS*ADDR_W-1:0] OFS_MAP = {
        OFS_PRIO_BANK_K, OFS_PRIO_BANK_J, OFS_PRIO_BANK_I, OFS_PRIO_BANK_H, OFS_PRIO_BANK_G,
        OFS_PRIO_BANK_F, OFS_PRIO_BANK_E, OFS_PRIO_BANK_D, OFS_PIN_IRQ_PRIORITY};

    // ----------------------------------------
    // field positions and values
    // ----------------------------------------
    localparam int FIELD_UPPER_LEVEL_B0 = 12;
    localparam int FIELD_SECOND_LEVEL_B0 = 8;
    localparam int FIELD_THIRD_LEVEL_B0 = 4;
    localparam int FIELD_LOWER_LEVEL_B0 = 0;
    localparam logic [REG_W-1:0] PRIO_RESET = 16'h0000;
    localparam logic [FIELD_W-1:0] LEVEL_MASKED = 4'h0;
    localparam logic [FIELD_W-1:0] LEVEL_MAX = 4'hF;
    localparam logic [4:0] NMI_LEVEL = 5'h10;

    typedef logic [FIELD_W-1:0] ipl_level_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [3:0] pstrb;
        logic [DATA_W-1:0] pwdata;
    } ipl_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } ipl_apb_rsp_t;

endpackage

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import ipl_pkg::*;
    // ----------------------------------------
    // clock, design and bench model
    // ----------------------------------------
    logic clk = 1'b0;
    logic reset = 1'b1;
    ipl_apb_req_t apb_req = '0;
    ipl_apb_rsp_t apb_rsp;
    logic [NUM_REGS*REG_W-1:0] src_level;
    logic [NUM_SRC-1:0] src_req = '0;
    logic nmi_req = 1'b0;
    logic [NUM_SRC-1:0] src_accept;
    logic nmi_accept;
    logic [4:0] nmi_level;
    logic [15:0] mreg [NUM_REGS];
    logic [31:0] rs = 32'h000181D0;
    int failures = 0;
    int compares = 0;

    always #4 clk = ~clk;

    ipl_bank u_ipl_bank (.clk(clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp), .src_level(src_level),
        .src_req(src_req), .nmi_req(nmi_req), .src_accept(src_accept), .nmi_accept(nmi_accept),
        .nmi_level(nmi_level));

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    task automatic check(input string what, input logic [NUM_REGS*REG_W-1:0] seen,
        input logic [NUM_REGS*REG_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // one bus cycle, compared against the model
    // ----------------------------------------
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        int idx;
        logic err;
        idx = int'(a >> 2);
        err = (a[1:0] != 2'h0) || (idx >= NUM_REGS);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pstrb <= s;
        apb_req.pwdata <= d;
        @(posedge clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            complete_run();
        end
        check("pslverr", apb_rsp.pslverr, err);
        if (!wr) check("prdata", apb_rsp.prdata, err ? 32'h0 : {16'h0, mreg[idx]});
        if (wr && !err && s[0]) mreg[idx][7:0] = d[7:0];
        if (wr && !err && s[1]) mreg[idx][15:8] = d[15:8];
        // release at the ready edge, then one idle edge before the next setup
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic read_all();
        for (int r = 0; r < NUM_REGS; r++) access(1'b0, 8'(r * 4), rnd(), 4'hF);
        @(negedge clk);
        for (int r = 0; r < NUM_REGS; r++) check("src_level", src_level[r*16 +: 16], mreg[r]);
        @(posedge clk);
    endtask

    task automatic gate_round();
        logic [NUM_SRC-1:0] r;
        logic [NUM_SRC-1:0] exp;
        logic [31:0] t;
        r = NUM_SRC'({rnd(), rnd()});
        t = rnd();
        src_req <= r;
        nmi_req <= t[7];
        @(posedge clk);
        @(negedge clk);
        for (int i = 0; i < NUM_SRC; i++) exp[i] = r[i] && (mreg[i/4][(i%4)*4 +: 4] != 4'h0);
        check("src_accept", src_accept, exp);
        check("nmi_accept", nmi_accept, t[7]);
        check("nmi_level", nmi_level, 5'h10);
        @(posedge clk);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        for (int r = 0; r < NUM_REGS; r++) mreg[r] = 16'h0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        read_all();
        $display("test reset values done");
        for (int r = 0; r < NUM_REGS; r++) access(1'b1, 8'(r * 4), rnd(), 4'hF);
        read_all();
        $display("test random writes done");
        for (int v = 0; v < 16; v++) access(1'b1, 8'((v % NUM_REGS) * 4), {8{v[3:0]}}, 4'hF);
        read_all();
        $display("test field values done");
        for (int s = 0; s < 4; s++) access(1'b1, 8'h14, rnd(), 4'(s));
        read_all();
        $display("test lane strobes done");
        access(1'b1, 8'h24, 32'hFFFFFFFF, 4'hF);
        access(1'b1, 8'h02, 32'hFFFFFFFF, 4'hF);
        access(1'b0, 8'hFC, 32'h0, 4'hF);
        read_all();
        $display("test unmapped addresses done");
        for (int r = 0; r < NUM_REGS; r++) access(1'b1, 8'(r * 4), rnd() & rnd(), 4'hF);
        access(1'b1, 8'h20, 32'h0, 4'hF);
        repeat (30) gate_round();
        $display("test accept gating done");
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        for (int r = 0; r < NUM_REGS; r++) mreg[r] = 16'h0;
        read_all();
        repeat (4) gate_round();
        $display("test reset in mid run done");
        complete_run();
    end
endmodule
